// ==== core/adc_pipe_defs.svh ====
// constants of the sampling converter's digital pipeline
// assumes a 125 MHz system clock; included by bare name
`ifndef ADC_PIPE_DEFS_SVH
`define ADC_PIPE_DEFS_SVH
`define CODE_W        8
`define CODE_ZERO     8'h00
`define CODE_ONES     8'hff
`define CLK_PERIOD_PS 32'h0000_1f40
`define SETTLE_NS     32'h0000_03e8
`define SETTLE_CYC    ((`SETTLE_NS * 32'h0000_03e8 + `CLK_PERIOD_PS - 32'h0000_0001) / `CLK_PERIOD_PS)
`define SETTLE_CNT_W  8
`define SYNC_STAGES   3
`endif

// ==== core/adc_pipe_pkg.sv ====
// types shared by the converter pipeline
// assumes nothing beyond the defs header
package adc_pipe_pkg;
  typedef enum logic [1:0] {PH_RUN, PH_SLEEP, PH_SETTLE} phase_t;
endpackage

// ==== core/adc_sample_pipeline.sv ====
// converter digital pipeline and its output fifo
// assumes conversion clock and sleep request are asynchronous pins
`timescale 1ns/1ps
`default_nettype none
`include "adc_pipe_defs.svh"

module sample_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  output logic              out_valid_out,
  output logic      [W-1:0] out_data_out,
  input  wire logic         out_ready_in
);
  localparam int PW = $clog2(DEPTH);
  // pointer wrap only works for power-of-two depths
  if (DEPTH < 2 || (1 << PW) != DEPTH || W < 1)
  begin : gen_bad_shape
    $error("sample_fifo: depth must be a power of two >= 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [PW:0]             cnt;
    logic                    ov;
    logic [W-1:0]            od;
  } fifo_st_t;

  fifo_st_t s_r;
  fifo_st_t s_nxt;
  logic     push;
  logic     pop;

  // ready is combinational so the producer stalls the same cycle
  assign in_ready_out  = (s_r.cnt != (PW+1)'(DEPTH));
  assign out_valid_out = s_r.ov;
  assign out_data_out  = s_r.od;

  always_comb
  begin
    s_nxt = s_r;
    push  = in_valid_in && in_ready_out;
    pop   = (s_r.cnt != '0) && (!s_r.ov || out_ready_in);
    if (out_ready_in)
      s_nxt.ov = 1'b0;
    if (pop)
    begin
      s_nxt.od = s_r.mem[s_r.rp];
      s_nxt.ov = 1'b1;
      s_nxt.rp = s_r.rp + 1'b1;
    end
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data_in;
      s_nxt.wp          = s_r.wp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule

module adc_sample_pipeline #(
  parameter int AW         = 12,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          conv_clk_in,
  input  wire logic          sleep_request_in,
  input  wire logic [AW-1:0] analog_level_in,
  input  wire logic [AW-1:0] bottom_reference_level_in,
  input  wire logic [AW-1:0] top_reference_level_in,
  output logic [`CODE_W-1:0] data_out,
  output logic               data_valid_out,
  output logic [`CODE_W-1:0] stream_data_out,
  output logic               stream_valid_out,
  input  wire logic          stream_ready_in
);
  if (AW < 2 || FIFO_DEPTH < 2)
  begin : gen_bad_shape
    $error("adc_sample_pipeline: unsupported width or depth");
  end

  localparam int CW = `CODE_W;
  localparam logic [`SETTLE_CNT_W-1:0] SETTLE_LAST = `SETTLE_CNT_W'(`SETTLE_CYC - 1);

  typedef struct packed {
    logic [`SYNC_STAGES-1:0]          conv_sync;
    logic [`SYNC_STAGES-1:0]          sleep_sync;
    logic [`SYNC_STAGES-1:0][AW-1:0]  ana_sync;
    logic [`SYNC_STAGES-1:0][AW-1:0]  bot_sync;
    logic [`SYNC_STAGES-1:0][AW-1:0]  top_sync;
    logic                             conv_lvl;
    logic                             sleep_lvl;
    adc_pipe_pkg::phase_t             phase;
    logic [`SETTLE_CNT_W-1:0]         settle_cnt;
    logic [CW-1:0]                    st1;
    logic [CW-1:0]                    st2;
    logic [CW-1:0]                    st3;
    logic [CW-1:0]                    word;
    logic                             word_valid;
  } pipe_st_t;

  pipe_st_t      s_r;
  pipe_st_t      s_nxt;
  logic          fall;
  logic          rise;
  logic          fifo_ready;
  logic          fifo_push;

  // linear quantiser with clamping at both ends of the ladder
  function automatic logic [CW-1:0] quantise(input logic [AW-1:0] x,
                                             input logic [AW-1:0] b,
                                             input logic [AW-1:0] t);
    logic [AW+CW-1:0] q;
    q = '0;
    if (x <= b || t <= b)
      quantise = `CODE_ZERO;
    else if (x >= t)
      quantise = `CODE_ONES;
    else
    begin
      q = {(x - b), {CW{1'b0}}} / {{CW{1'b0}}, (t - b)};
      quantise = (q > (AW+CW)'(`CODE_ONES)) ? `CODE_ONES : q[CW-1:0];
    end
  endfunction

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.conv_sync  = {s_r.conv_sync[`SYNC_STAGES-2:0], conv_clk_in};
    s_nxt.sleep_sync = {s_r.sleep_sync[`SYNC_STAGES-2:0], sleep_request_in};
    s_nxt.ana_sync   = {s_r.ana_sync[`SYNC_STAGES-2:0], analog_level_in};
    // ladder ends are static pins, so plain stages suffice, no vote
    s_nxt.bot_sync   = {s_r.bot_sync[`SYNC_STAGES-2:0], bottom_reference_level_in};
    s_nxt.top_sync   = {s_r.top_sync[`SYNC_STAGES-2:0], top_reference_level_in};
    // a pin change counts once the last two stages agree
    if (s_r.conv_sync[1] == s_r.conv_sync[2])
      s_nxt.conv_lvl = s_r.conv_sync[2];
    if (s_r.sleep_sync[1] == s_r.sleep_sync[2])
      s_nxt.sleep_lvl = s_r.sleep_sync[2];
    // edges exist only while the clock runs, so a halt freezes the stages and the word
    fall = (s_r.conv_lvl && !s_nxt.conv_lvl);
    rise = (!s_r.conv_lvl && s_nxt.conv_lvl);
    fifo_push = 1'b0;

    case (s_r.phase)
      adc_pipe_pkg::PH_RUN:
      begin
        if (s_r.sleep_lvl)
          s_nxt.phase = adc_pipe_pkg::PH_SLEEP;
      end
      adc_pipe_pkg::PH_SLEEP:
      begin
        if (!s_r.sleep_lvl)
        begin
          s_nxt.phase      = adc_pipe_pkg::PH_SETTLE;
          s_nxt.settle_cnt = '0;
        end
      end
      adc_pipe_pkg::PH_SETTLE:
      begin
        s_nxt.settle_cnt = s_r.settle_cnt + 1'b1;
        if (s_r.sleep_lvl)
          s_nxt.phase = adc_pipe_pkg::PH_SLEEP;
        else if (s_r.settle_cnt == SETTLE_LAST)
          s_nxt.phase = adc_pipe_pkg::PH_RUN;
      end
      default:
        s_nxt.phase = adc_pipe_pkg::PH_RUN;
    endcase

    // sleeping blocks all stages; a full fifo also stalls conversion
    if (s_r.phase != adc_pipe_pkg::PH_SLEEP && !s_r.sleep_lvl && fifo_ready)
    begin
      if (fall)
      begin
        s_nxt.st1 = quantise(s_r.ana_sync[`SYNC_STAGES-1],
                             s_r.bot_sync[`SYNC_STAGES-1], s_r.top_sync[`SYNC_STAGES-1]);
        s_nxt.st2 = s_r.st1;
        s_nxt.st3 = s_r.st2;
      end
      if (rise)
      begin
        s_nxt.word       = s_r.st3;
        s_nxt.word_valid = (s_r.phase == adc_pipe_pkg::PH_RUN);
        fifo_push        = (s_r.phase == adc_pipe_pkg::PH_RUN);
      end
    end
    else if (s_r.phase != adc_pipe_pkg::PH_RUN)
      s_nxt.word_valid = 1'b0;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      s_r       <= '0;
      s_r.phase <= adc_pipe_pkg::PH_RUN;
    end
    else
      s_r <= s_nxt;
  end

  assign data_out       = s_r.word;
  assign data_valid_out = s_r.word_valid;

  sample_fifo #(
    .W     (CW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (fifo_push),
    .in_data_in    (s_nxt.word),
    .in_ready_out  (fifo_ready),
    .out_valid_out (stream_valid_out),
    .out_data_out  (stream_data_out),
    .out_ready_in  (stream_ready_in)
  );
endmodule

`default_nettype wire

// ==== testbench/adc_pipe_checker.sv ====
// port-level timing checks for the converter pipeline
// assumes conv clock half period of at least 4 clk_in
`timescale 1ns/1ps
`default_nettype none
`include "adc_pipe_defs.svh"
module adc_pipe_checker (
  input wire logic              clk_in,
  input wire logic              rst_n_in,
  input wire logic              conv_clk_in,
  input wire logic              sleep_request_in,
  input wire logic [`CODE_W-1:0] data_out,
  input wire logic              data_valid_out,
  input wire logic [`CODE_W-1:0] stream_data_out,
  input wire logic              stream_valid_out,
  input wire logic              stream_ready_in
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  out_on_rise_a: assert property (
    $changed(data_out) |-> $past(conv_clk_in, 2) && !$past(conv_clk_in, 6))
    else $error("word moved away from a rise");
  valid_on_rise_a: assert property (
    $rose(data_valid_out) |-> $past(conv_clk_in, 2) && !$past(conv_clk_in, 6))
    else $error("valid rose away from a rise");
  sleep_hold_a: assert property (
    sleep_request_in [*8] |-> $stable(data_out))
    else $error("word moved in sleep");
  sleep_no_valid_a: assert property (
    sleep_request_in [*8] |-> !$rose(data_valid_out))
    else $error("valid rose in sleep");
  stop_hold_a: assert property (
    $stable(conv_clk_in) [*6] |-> $stable(data_out))
    else $error("word moved with clock stopped");
  settle_low_a: assert property (
    $fell(sleep_request_in) |-> ##6 !data_valid_out [*8] ##60 !data_valid_out)
    else $error("valid during settling");
  settle_end_a: assert property (
    $fell(sleep_request_in) |-> ##[130:400] data_valid_out)
    else $error("no valid word after wake");
  stream_hold_a: assert property (
    stream_valid_out && !stream_ready_in |=> stream_valid_out && $stable(stream_data_out))
    else $error("stream word dropped");
endmodule
bind adc_sample_pipeline adc_pipe_checker chk (.*);
`default_nettype wire

// ==== testbench/conv_host_model.sv ====
// host model: conversion clock source and stream consumer
// assumes run, stall and slow come from the bench after clock edges
`timescale 1ns/1ps
`default_nettype none
module conv_host_model #(parameter int HALF = 4) (
  input  wire logic clk_in,
  input  wire logic run_in,
  input  wire logic stall_in,
  input  wire logic slow_in,
  output logic      conv_clk_out,
  output logic      ready_out
);
  int   cnt    = 0;
  logic tick   = 1'b0;
  logic conv_r = 1'b0;
  assign conv_clk_out = conv_r;
  // stops only low, so no short high phase
  always @(posedge clk_in)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    tick <= ~tick;
    if (cnt == HALF - 1 && (run_in || conv_r))
      conv_r <= ~conv_r;
  end
  assign ready_out = !stall_in && (!slow_in || tick);
endmodule
`default_nettype wire

// ==== testbench/adc_sample_output_pipeline_tb_top.sv ====
// self-checking bench for the converter pipeline
// assumes host model makes conv clock and stream ready
`timescale 1ns/1ps
`default_nettype none
module adc_sample_output_pipeline_tb_top;
  localparam logic [11:0] B = 12'h100;
  localparam logic [11:0] T = 12'hf00;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sleep_request_in = 1'b0;
  logic run = 1'b0, stall = 1'b0, slow = 1'b0, lax = 1'b0;
  logic [11:0] analog_level_in = 12'h000;
  logic [11:0] bottom_reference_level_in = B;
  logic [11:0] top_reference_level_in = T;
  logic [11:0] edges [5] = '{12'h0ff, 12'h100, 12'h880, 12'hf00, 12'hfff};
  wire logic conv_clk_in, data_valid_out, stream_valid_out, stream_ready_in;
  wire logic [7:0] data_out, stream_data_out;
  int error_cnt = 0, samples_checked = 0, seed = 15197, nword = 0, cyc = 0;
  logic [7:0] expq [$];
  logic [11:0] h [$];
  initial forever #4 clk_in = ~clk_in;
  adc_sample_pipeline dut (.*);
  conv_host_model host (.clk_in, .run_in(run), .stall_in(stall), .slow_in(slow),
    .conv_clk_out(conv_clk_in), .ready_out(stream_ready_in));
  function automatic logic [7:0] code(input logic [11:0] x);
    if (x <= B) return 8'h00;
    if (x >= T) return 8'hff;
    return 8'(int'(x - B) * 256 / int'(T - B));
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // three stale pads lead each burst, four trail it
  task automatic burst(input int n);
    logic [11:0] v;
    h = {};
    run = 1'b1;
    for (int i = 0; i <= n + 3; i++)
    begin
      @(posedge conv_clk_in);
      expq.push_back(i < 3 ? 8'h00 : code(h[i - 3]));
      #1;
      v = i >= n ? 12'h000 : i < 5 ? edges[i] : 12'($random(seed));
      h.push_back(v);
      analog_level_in = v;
    end
    run = 1'b0;
    idle(40);
    check(8'(expq.size()), 8'h00);
    $display("burst of %0d done", n);
  endtask
  always @(posedge clk_in)
  begin
    cyc++;
    if (rst_n_in && stream_valid_out === 1'b1 && stream_ready_in === 1'b1)
      if (lax)
        nword++;
      else
        check(stream_data_out, expq.size() ? expq.pop_front() : 8'hxx);
    if (cyc == 3000)
    begin
      error_cnt++;
      stop_test();
    end
  end
  initial
  begin
    idle(3);
    rst_n_in = 1'b1;
    idle(4);
    burst(24);
    slow = 1'b1;
    sleep_request_in = 1'b1;
    idle(8);
    run = 1'b1;
    // a live input would drive the word to ff unless frozen
    analog_level_in = T;
    idle(48);
    run = 1'b0;
    idle(12);
    check(data_out, 8'h00);
    check(8'(data_valid_out), 8'h00);
    $display("sleep test done");
    sleep_request_in = 1'b0;
    idle(60);
    check(8'(data_valid_out), 8'h00);
    idle(80);
    burst(12);
    check(8'(data_valid_out), 8'h01);
    stall = 1'b1;
    lax = 1'b1;
    run = 1'b1;
    idle(220);
    run = 1'b0;
    idle(10);
    stall = 1'b0;
    idle(60);
    check(8'(nword), 8'h11);
    $display("stall test done");
    stop_test();
  end
endmodule
`default_nettype wire
